// ===== core/pic_params.svh
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH

// ==========================================================================
// Port select values and write decode bits
`define PIC_PORT_LOW      1'b0
`define PIC_PORT_HIGH     1'b1
`define PIC_SEL_IW1_BIT   4
`define PIC_SEL_OW3_BIT   3

// ==========================================================================
// Field positions of the init and operation words
`define PIC_IW1_LEVEL_SENSE_SELECT_BIT  3
`define PIC_IW1_ADI_BIT   2
`define PIC_IW1_SNGL_BIT  1
`define PIC_IW1_IC4_BIT   0
`define PIC_IW4_BUF_BIT   3
`define PIC_IW4_MS_BIT    2
`define PIC_IW4_AUTO_END_OF_SERVICE_BIT  1
`define PIC_IW4_UPM_BIT   0
`define PIC_OW3_POLL_BIT  2
`define PIC_OW3_RR_BIT    1
`define PIC_OW3_RIS_BIT   0
`define PIC_POLL_IRQ_BIT  7

// ==========================================================================
// Codes and reset values
`define PIC_CALL_OPCODE   8'hCD
`define PIC_EOI_NONSPEC   3'h1
`define PIC_EOI_SPEC      3'h3
`define PIC_LEVEL_SPUR    3'h7
`define PIC_SLAVE_ID_RST  8'h07
`define PIC_BYTE_RST      8'h00
`define PIC_SYNC_W        25
`define PIC_SYNC_RST      25'h001E001

`endif

// ===== core/pic_pkg.sv
`default_nettype none

package pic_pkg;

   // ==========================================================================
   // Acknowledge sequence: number of strobe pulses seen so far
   typedef enum logic [1:0] {
      PIC_ACK_IDLE  = 2'b00,
      PIC_ACK_ONE   = 2'b01,
      PIC_ACK_TWO   = 2'b10,
      PIC_ACK_THREE = 2'b11
   } pic_ack_type;

   // Init word expected next on the high port
   typedef enum logic [1:0] {
      PIC_INIT_READY = 2'b00,
      PIC_INIT_TWO   = 2'b01,
      PIC_INIT_THREE = 2'b10,
      PIC_INIT_FOUR  = 2'b11
   } pic_init_type;

   // Lowest set bit; level 0 is the highest priority
   function automatic logic [2:0] pic_lowest_bit(input logic [7:0] vec);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (vec[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction : pic_lowest_bit

   function automatic logic [7:0] pic_level_bit(input logic [2:0] lvl);
      return 8'h01 << lvl;
   endfunction : pic_level_bit

endpackage : pic_pkg

`default_nettype wire

// ===== core/pic_res_if.sv
`default_nettype none

interface pic_res_if;
   logic [7:0] pend;
   logic [7:0] mask;
   logic [7:0] serv;
   logic       req_any;
   logic [2:0] req_level;
   logic       serv_any;
   logic [2:0] serv_top;
   logic       irq_want;

   modport core (output pend, mask, serv,
                 input  req_any, req_level, serv_any, serv_top, irq_want);
   modport res  (input  pend, mask, serv,
                 output req_any, req_level, serv_any, serv_top, irq_want);
endinterface : pic_res_if

`default_nettype wire

// ===== core/pic_resolver.sv
`default_nettype none

module pic_resolver (
   // Resolver view
   pic_res_if.res res
);

   logic [7:0] live;

   // ==========================================================================
   // Fully nested priority: a request must beat the highest level in service
   always_comb begin
      live          = res.pend & ~res.mask;
      res.req_any   = |live;
      res.req_level = pic_pkg::pic_lowest_bit(live);
      res.serv_any  = |res.serv;
      res.serv_top  = pic_pkg::pic_lowest_bit(res.serv);
      res.irq_want  = res.req_any && (!res.serv_any || (res.req_level < res.serv_top)); // [R8]
   end

endmodule : pic_resolver

`default_nettype wire

// ===== core/pic_core.sv
//
// Contract
// R1: Read with select low drives request/service/poll on port 0, mask on port 1.
// R2: Port 0 writes decode by bits 4 and 3; port 1 writes mask or init words.
// R3: Data bus floats when deselected without acknowledge, or read and write both high.
// R4: Host never drives read and write low together; that case is ignored.
// R5: Eight levels here; cascading identical controllers reaches sixty-four levels.
// R6: Rising request lines set pending bits; service bits hold levels being handled.
// R7: Raise the CPU interrupt line when a qualifying unmasked request is pending.
// R8: Resolver picks highest pending level; acknowledge sets its service bit.
// R9: First acknowledge sets winning service bit and clears its pending bit.
// R10: CPU answers the interrupt line with an acknowledge pulse.
// R11: Three-pulse mode drives the call opcode during the first pulse.
// R12: Three-pulse mode: CPU sends two more pulses for the routine address.
// R13: Second pulse gives low address byte, third pulse the high byte.
// R14: Three-pulse mode with auto end clears service bit after third pulse.
// R15: Without auto end the service bit stays until an end command.
// R16: Two-pulse mode keeps the data bus floating during the first pulse.
// R17: Two-pulse mode drives an eight-bit vector during the second pulse.
// R18: Two-pulse mode with auto end clears service bit after second pulse.
// R19: A request gone before the first pulse answers as level seven.
// R20: Master drives the slave identity on chain lines; slave reads them.
// R21: Selected slave drives its routine bytes on the following pulses.
// R22: Vector holds five type bits above the three-bit level number.
// R23: Low address byte inserts level times four or times eight.
// R24: Level mode latches on high inputs; edge mode needs a rising edge.
// R25: Asynchronous inputs pass two flip-flops; strobe edges are detected.
`default_nettype none
`include "pic_params.svh"

module pic_core (
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       srst_i,
   // Host bus
   input  wire logic       cs_n_i,
   input  wire logic       rd_n_i,
   input  wire logic       wr_n_i,
   input  wire logic       port_select_i,
   input  wire logic [7:0] data_i,
   output logic      [7:0] data_o,
   output logic            data_oe_n_o,
   // Requests and acknowledge
   input  wire logic [7:0] request_lines_i,
   input  wire logic       acknowledge_strobe_n_i,
   output logic            cpu_irq_o,
   // Cascade
   input  wire logic [2:0] chain_id_lines_i,
   output logic      [2:0] chain_id_lines_o,
   output logic            chain_id_lines_oe_n_o,
   input  wire logic       slave_program_n_i
);

   // ==========================================================================
   // Input synchronisers
   logic [`PIC_SYNC_W-1:0] sync1_q;
   logic [`PIC_SYNC_W-1:0] sync2_q;
   logic [7:0]             req_s;
   logic                   cs_n_s;
   logic                   rd_n_s;
   logic                   wr_n_s;
   logic                   ack_n_s;
   logic                   a0_s;
   logic [7:0]             data_s;
   logic [2:0]             chain_s;
   logic                   sp_n_s;

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         sync1_q <= `PIC_SYNC_RST;
         sync2_q <= `PIC_SYNC_RST;
      end else begin
         sync1_q <= {request_lines_i, cs_n_i, rd_n_i, wr_n_i, acknowledge_strobe_n_i,
                     port_select_i, data_i, chain_id_lines_i, slave_program_n_i}; // [R25]
         sync2_q <= sync1_q;
      end
   end

   assign {req_s, cs_n_s, rd_n_s, wr_n_s, ack_n_s, a0_s, data_s, chain_s, sp_n_s} = sync2_q;

   // ==========================================================================
   // Control state
   pic_res_if res_if ();

   pic_resolver u_resolver (
      .res (res_if.res)
   );

   logic [7:0]           req_prev_q, req_prev_d;
   logic                 rd_prev_q, rd_prev_d;
   logic                 wr_prev_q, wr_prev_d;
   logic                 ack_prev_q, ack_prev_d;
   logic [7:0]           irr_q, irr_d;
   logic [7:0]           isr_q, isr_d;
   logic [7:0]           imr_q, imr_d;
   logic [7:0]           iw1_q, iw1_d;
   logic [7:0]           iw2_q, iw2_d;
   logic [7:0]           iw3_q, iw3_d;
   logic [7:0]           iw4_q, iw4_d;
   logic                 ris_q, ris_d;
   logic                 poll_q, poll_d;
   logic [7:0]           wdat_q, wdat_d;
   logic                 wa0_q, wa0_d;
   logic                 wsel_q, wsel_d;
   logic [2:0]           level_q, level_d;
   logic                 real_q, real_d;
   pic_pkg::pic_ack_type  ack_q, ack_d;
   pic_pkg::pic_init_type init_q, init_d;

   logic [7:0] rise;
   logic [7:0] isr_set;
   logic [7:0] isr_clr;
   logic [7:0] irr_clr;
   logic       ack_fall;
   logic       ack_rise;
   logic       wr_stb;
   logic       rd_end;
   logic       iw1_stb;
   logic       level_sense_select;
   logic       upm;
   logic       auto_end_of_service;
   logic       single;
   logic       master;
   logic       own_bytes;
   logic       last_pulse;

   assign res_if.pend = irr_q;
   assign res_if.mask = imr_q;
   assign res_if.serv = isr_q;

   assign level_sense_select     = iw1_q[`PIC_IW1_LEVEL_SENSE_SELECT_BIT];
   assign single   = iw1_q[`PIC_IW1_SNGL_BIT];
   assign upm      = iw4_q[`PIC_IW4_UPM_BIT];
   assign auto_end_of_service     = iw4_q[`PIC_IW4_AUTO_END_OF_SERVICE_BIT];
   // Buffered mode takes the role from the init word, otherwise from the strap pin
   assign master   = iw4_q[`PIC_IW4_BUF_BIT] ? iw4_q[`PIC_IW4_MS_BIT] : sp_n_s;
   assign ack_fall = ack_prev_q && !ack_n_s; // [R25]
   assign ack_rise = !ack_prev_q && ack_n_s;
   // Writes take effect at the trailing edge, when the data has settled
   assign wr_stb   = !wr_prev_q && wr_n_s && wsel_q;
   assign rd_end   = !rd_prev_q && rd_n_s && !cs_n_s;
   assign iw1_stb  = wr_stb && (wa0_q == `PIC_PORT_LOW) && wdat_q[`PIC_SEL_IW1_BIT];
   assign rise     = req_s & ~req_prev_q;
   assign last_pulse = (upm && (ack_q == pic_pkg::PIC_ACK_TWO)) ||
                       (ack_q == pic_pkg::PIC_ACK_THREE);
   // Master yields the address bytes to a slave hanging on the serviced level
   assign own_bytes = single ? 1'b1 :
                      (master ? !iw3_q[level_q] : (chain_s == iw3_q[2:0])); // [R5] [R20] [R21]

   always_comb begin
      req_prev_d = req_s;
      rd_prev_d  = rd_n_s;
      wr_prev_d  = wr_n_s;
      ack_prev_d = ack_n_s;
      imr_d      = imr_q;
      iw1_d      = iw1_q;
      iw2_d      = iw2_q;
      iw3_d      = iw3_q;
      iw4_d      = iw4_q;
      ris_d      = ris_q;
      poll_d     = poll_q;
      level_d    = level_q;
      real_d     = real_q;
      ack_d      = ack_q;
      init_d     = init_q;
      wdat_d     = wdat_q;
      wa0_d      = wa0_q;
      wsel_d     = wsel_q;
      isr_set    = `PIC_BYTE_RST;
      isr_clr    = `PIC_BYTE_RST;
      irr_clr    = `PIC_BYTE_RST;

      // Capture write data while the strobe is low; both strobes low is ignored
      if (!wr_n_s) begin
         wdat_d = data_s;
         wa0_d  = a0_s;
         wsel_d = !cs_n_s && rd_n_s; // [R4]
      end

      // Acknowledge sequence
      if (ack_fall) begin
         case (ack_q)
            pic_pkg::PIC_ACK_IDLE: begin
               ack_d   = pic_pkg::PIC_ACK_ONE;
               level_d = res_if.req_any ? res_if.req_level : `PIC_LEVEL_SPUR; // [R19]
               real_d  = res_if.req_any;
               if (res_if.req_any) begin
                  isr_set = pic_pkg::pic_level_bit(res_if.req_level); // [R8] [R9]
                  irr_clr = pic_pkg::pic_level_bit(res_if.req_level); // [R9]
               end
            end
            pic_pkg::PIC_ACK_ONE:   ack_d = pic_pkg::PIC_ACK_TWO;
            pic_pkg::PIC_ACK_TWO:   ack_d = pic_pkg::PIC_ACK_THREE; // [R12]
            default:                ack_d = ack_q;
         endcase
      end else if (ack_rise && last_pulse) begin
         ack_d = pic_pkg::PIC_ACK_IDLE;
         if (auto_end_of_service && real_q) begin
            isr_clr = pic_pkg::pic_level_bit(level_q); // [R14] [R18]
         end
      end

      // Poll read acts as an acknowledge of the winning level
      if (rd_end && poll_q && (a0_s == `PIC_PORT_LOW)) begin
         poll_d = 1'b0;
         if (res_if.req_any) begin
            isr_set = isr_set | pic_pkg::pic_level_bit(res_if.req_level);
            irr_clr = irr_clr | pic_pkg::pic_level_bit(res_if.req_level);
         end
      end

      // Register writes
      if (iw1_stb) begin // [R2]
         iw1_d  = wdat_q;
         imr_d  = `PIC_BYTE_RST;
         ris_d  = 1'b0;
         poll_d = 1'b0;
         iw3_d  = `PIC_SLAVE_ID_RST;
         init_d = pic_pkg::PIC_INIT_TWO;
         if (!wdat_q[`PIC_IW1_IC4_BIT]) begin
            iw4_d = `PIC_BYTE_RST;
         end
      end else if (wr_stb && (wa0_q == `PIC_PORT_LOW)) begin
         if (wdat_q[`PIC_SEL_OW3_BIT]) begin // [R2]
            if (wdat_q[`PIC_OW3_RR_BIT]) begin
               ris_d = wdat_q[`PIC_OW3_RIS_BIT];
            end
            poll_d = wdat_q[`PIC_OW3_POLL_BIT];
         end else if (wdat_q[7:5] == `PIC_EOI_NONSPEC) begin
            if (res_if.serv_any) begin
               isr_clr = isr_clr | pic_pkg::pic_level_bit(res_if.serv_top); // [R15]
            end
         end else if (wdat_q[7:5] == `PIC_EOI_SPEC) begin
            isr_clr = isr_clr | pic_pkg::pic_level_bit(wdat_q[2:0]); // [R15]
         end
      end else if (wr_stb) begin
         case (init_q) // [R2]
            pic_pkg::PIC_INIT_TWO: begin
               iw2_d = wdat_q;
               if (!iw1_q[`PIC_IW1_SNGL_BIT]) begin
                  init_d = pic_pkg::PIC_INIT_THREE;
               end else if (iw1_q[`PIC_IW1_IC4_BIT]) begin
                  init_d = pic_pkg::PIC_INIT_FOUR;
               end else begin
                  init_d = pic_pkg::PIC_INIT_READY;
               end
            end
            pic_pkg::PIC_INIT_THREE: begin
               iw3_d  = wdat_q;
               init_d = iw1_q[`PIC_IW1_IC4_BIT] ? pic_pkg::PIC_INIT_FOUR
                                                : pic_pkg::PIC_INIT_READY;
            end
            pic_pkg::PIC_INIT_FOUR: begin
               iw4_d  = wdat_q;
               init_d = pic_pkg::PIC_INIT_READY;
            end
            default: imr_d = wdat_q;
         endcase
      end

      // Pending requests: a new edge wins over a clear in the same cycle
      if (iw1_stb) begin
         irr_d = `PIC_BYTE_RST;
      end else if (level_sense_select) begin
         irr_d = req_s; // [R24]
      end else begin
         irr_d = ((irr_q & ~irr_clr) | rise) & req_s; // [R6] [R24]
      end
      isr_d = (isr_q & ~isr_clr) | isr_set;
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         req_prev_q <= `PIC_BYTE_RST;
         rd_prev_q  <= 1'b1;
         wr_prev_q  <= 1'b1;
         ack_prev_q <= 1'b1;
         irr_q      <= `PIC_BYTE_RST;
         isr_q      <= `PIC_BYTE_RST;
         imr_q      <= `PIC_BYTE_RST;
         iw1_q      <= `PIC_BYTE_RST;
         iw2_q      <= `PIC_BYTE_RST;
         iw3_q      <= `PIC_SLAVE_ID_RST;
         iw4_q      <= `PIC_BYTE_RST;
         ris_q      <= 1'b0;
         poll_q     <= 1'b0;
         wdat_q     <= `PIC_BYTE_RST;
         wa0_q      <= `PIC_PORT_LOW;
         wsel_q     <= 1'b0;
         level_q    <= `PIC_LEVEL_SPUR;
         real_q     <= 1'b0;
         ack_q      <= pic_pkg::PIC_ACK_IDLE;
         init_q     <= pic_pkg::PIC_INIT_READY;
      end else begin
         req_prev_q <= req_prev_d;
         rd_prev_q  <= rd_prev_d;
         wr_prev_q  <= wr_prev_d;
         ack_prev_q <= ack_prev_d;
         irr_q      <= irr_d;
         isr_q      <= isr_d;
         imr_q      <= imr_d;
         iw1_q      <= iw1_d;
         iw2_q      <= iw2_d;
         iw3_q      <= iw3_d;
         iw4_q      <= iw4_d;
         ris_q      <= ris_d;
         poll_q     <= poll_d;
         wdat_q     <= wdat_d;
         wa0_q      <= wa0_d;
         wsel_q     <= wsel_d;
         level_q    <= level_d;
         real_q     <= real_d;
         ack_q      <= ack_d;
         init_q     <= init_d;
      end
   end

   // ==========================================================================
   // Pin outputs
   logic [7:0] data_q, data_d;
   logic       data_oe_n_q, data_oe_n_d;
   logic       irq_q, irq_d;
   logic [2:0] chain_q, chain_d;
   logic       chain_oe_n_q, chain_oe_n_d;
   logic [7:0] low_addr;
   logic [7:0] vector;

   always_comb begin
      // Interval 4 keeps three programmed bits, interval 8 keeps two
      low_addr = iw1_q[`PIC_IW1_ADI_BIT] ? {iw1_q[7:5], level_q, 2'b00}
                                         : {iw1_q[7:6], level_q, 3'b000}; // [R23]
      vector   = {iw2_q[7:3], level_q}; // [R22]
      data_d      = `PIC_BYTE_RST;
      data_oe_n_d = 1'b1;
      irq_d       = res_if.irq_want; // [R7]
      chain_d     = level_q; // [R20]
      chain_oe_n_d = !(master && !single); // [R20]
      if (!ack_n_s && (ack_q != pic_pkg::PIC_ACK_IDLE)) begin
         case (ack_q)
            pic_pkg::PIC_ACK_ONE: begin
               if (!upm && (master || single)) begin // [R16]
                  data_d      = `PIC_CALL_OPCODE; // [R11]
                  data_oe_n_d = 1'b0;
               end
            end
            pic_pkg::PIC_ACK_TWO: begin
               if (own_bytes) begin
                  data_d      = upm ? vector : low_addr; // [R13] [R17] [R21]
                  data_oe_n_d = 1'b0;
               end
            end
            default: begin
               if (own_bytes) begin
                  data_d      = iw2_q; // [R13]
                  data_oe_n_d = 1'b0;
               end
            end
         endcase
      end else if (!cs_n_s && !rd_n_s && wr_n_s) begin // [R3] [R4]
         data_oe_n_d = 1'b0;
         if (a0_s == `PIC_PORT_HIGH) begin
            data_d = imr_q; // [R1]
         end else if (poll_q) begin
            data_d = {res_if.irq_want, 4'h0, res_if.req_level}; // [R1]
         end else begin
            data_d = ris_q ? isr_q : irr_q; // [R1]
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         data_q       <= `PIC_BYTE_RST;
         data_oe_n_q  <= 1'b1;
         irq_q        <= 1'b0;
         chain_q      <= `PIC_LEVEL_SPUR;
         chain_oe_n_q <= 1'b1;
      end else begin
         data_q       <= data_d;
         data_oe_n_q  <= data_oe_n_d;
         irq_q        <= irq_d;
         chain_q      <= chain_d;
         chain_oe_n_q <= chain_oe_n_d;
      end
   end

   assign data_o                = data_q;
   assign data_oe_n_o           = data_oe_n_q;
   assign cpu_irq_o             = irq_q;
   assign chain_id_lines_o      = chain_q;
   assign chain_id_lines_oe_n_o = chain_oe_n_q;

   // ==========================================================================
   // Checks
   AST_READ_MASK: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R1]
      (ack_n_s && !cs_n_s && !rd_n_s && wr_n_s && a0_s) |=>
      (!data_oe_n_o && (data_o == $past(imr_q))))
      else $error("mask read not driven");
   AST_FLOAT_IDLE: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R3]
      (cs_n_s && ack_n_s) |=> data_oe_n_o)
      else $error("bus driven while idle");
   AST_CALL_BYTE: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R11]
      ((ack_q == pic_pkg::PIC_ACK_ONE) && !ack_n_s && !upm && single) |=>
      (!data_oe_n_o && (data_o == `PIC_CALL_OPCODE)))
      else $error("call opcode missing");
   AST_FIRST_FLOAT: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R16]
      ((ack_q == pic_pkg::PIC_ACK_ONE) && !ack_n_s && upm) |=> data_oe_n_o)
      else $error("bus driven on first pulse");
   AST_ISR_SET: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R9]
      (ack_fall && (ack_q == pic_pkg::PIC_ACK_IDLE) && res_if.req_any) |=>
      (isr_q[level_q] && (ack_q == pic_pkg::PIC_ACK_ONE)))
      else $error("service bit not set");
   AST_SPURIOUS: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R19]
      (ack_fall && (ack_q == pic_pkg::PIC_ACK_IDLE) && !res_if.req_any) |=>
      ((level_q == `PIC_LEVEL_SPUR) && !real_q))
      else $error("spurious level wrong");
   AST_AUTO_END: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R14] [R18]
      (ack_rise && last_pulse && auto_end_of_service && real_q && !ack_fall) |=>
      (!isr_q[$past(level_q)] && (ack_q == pic_pkg::PIC_ACK_IDLE)))
      else $error("auto end missed");
   AST_VECTOR: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R17] [R22]
      ((ack_q == pic_pkg::PIC_ACK_TWO) && !ack_n_s && upm && single) |=>
      (!data_oe_n_o && (data_o == {$past(iw2_q[7:3]), $past(level_q)})))
      else $error("vector byte wrong");
   AST_EDGE_SET: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R6] [R24]
      (!level_sense_select && rise[0] && !iw1_stb) |=> irr_q[0])
      else $error("edge request lost");
   AST_IRQ_CAUSE: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R7]
      $rose(cpu_irq_o) |-> $past(res_if.req_any, 1))
      else $error("interrupt without request");

endmodule : pic_core

`default_nettype wire

// ===== dv/pic_host_model.sv
`default_nettype none
// ==========================================================
// Host CPU model: bus cycles and acknowledge pulses
module pic_host_model (
   // Clock
   input  wire logic       clk_i,
   // Host bus
   output logic            cs_n_o,
   output logic            rd_n_o,
   output logic            wr_n_o,
   output logic            a0_o,
   output logic      [7:0] data_o,
   output logic            ack_n_o,
   // Device answer
   input  wire logic [7:0] dev_data_i,
   input  wire logic       dev_oe_n_i
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {cs_n_o, rd_n_o, wr_n_o, ack_n_o} = 4'hF;
      a0_o = 1'b0;
      data_o = 8'h00;
   end
   // Read stays high through a write; never both low
   task automatic wr_reg(input logic a0, input logic [7:0] d);
      @(negedge clk_i);
      {cs_n_o, a0_o, data_o, wr_n_o} = {1'b0, a0, d, 1'b0};
      repeat (3) @(negedge clk_i);
      wr_n_o = 1'b1;
      repeat (2) @(negedge clk_i);
      cs_n_o = 1'b1;
      data_o = ~d; // Released bus shows no stale value
      repeat (4) @(negedge clk_i);
   endtask : wr_reg
   task automatic rd_reg(input logic a0, output logic [7:0] d, output logic oe_n);
      @(negedge clk_i);
      {cs_n_o, a0_o, rd_n_o} = {1'b0, a0, 1'b0};
      repeat (4) @(negedge clk_i);
      {d, oe_n} = {dev_data_i, dev_oe_n_i};
      {cs_n_o, rd_n_o} = 2'h3;
      repeat (4) @(negedge clk_i);
   endtask : rd_reg
   // Pulses do not wait for the interrupt line; counted per mode by caller
   task automatic ack(output logic [7:0] d, output logic oe_n);
      @(negedge clk_i);
      ack_n_o = 1'b0;
      repeat (4) @(negedge clk_i);
      {d, oe_n} = {dev_data_i, dev_oe_n_i};
      ack_n_o = 1'b1;
      repeat (4) @(negedge clk_i);
   endtask : ack
endmodule : pic_host_model
`default_nettype wire

// ===== dv/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic       ref_clk_i = 1'b0;
   logic       srst_i = 1'b1;
   logic       cs_n, rd_n, wr_n, a0, ack_n, oe_n, irq, coe_n;
   logic [7:0] din, dout, req = 8'h00, d;
   logic [2:0] cid;
   int         failures = 0;
   int         n_compared = 0;
   int         cyc = 0;
   logic       o;
   initial forever #50 ref_clk_i = ~ref_clk_i;
   pic_host_model HOST (.clk_i(ref_clk_i), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
      .a0_o(a0), .data_o(din), .ack_n_o(ack_n), .dev_data_i(dout), .dev_oe_n_i(oe_n));
   pic_core DUT (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .cs_n_i(cs_n), .rd_n_i(rd_n),
      .wr_n_i(wr_n), .port_select_i(a0), .data_i(din), .data_o(dout), .data_oe_n_o(oe_n),
      .request_lines_i(req), .acknowledge_strobe_n_i(ack_n), .cpu_irq_o(irq),
      .chain_id_lines_i(3'h0), .chain_id_lines_o(cid), .chain_id_lines_oe_n_o(coe_n),
      .slave_program_n_i(1'b1));
   task automatic finish_test();
      if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         finish_test();
      end
   end
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic init(input logic [7:0] w1, input logic [7:0] w2, input logic [7:0] w4);
      HOST.wr_reg(1'b0, w1);
      HOST.wr_reg(1'b1, w2);
      HOST.wr_reg(1'b1, w4);
      HOST.wr_reg(1'b1, 8'h00);
   endtask : init
   task automatic raise(input logic [7:0] r);
      @(negedge ref_clk_i) req = r;
      repeat (6) @(negedge ref_clk_i);
   endtask : raise
   // Call form, interval 4, level 3, then end command
   task automatic t_three_pulse();
      init(8'hF7, 8'h5A, 8'h00);
      raise(8'h08);
      chk("irq", 8'h01, {7'h0, irq});
      HOST.ack(d, o);
      chk("call", 8'hCD, d);
      HOST.ack(d, o);
      chk("low addr", 8'hEC, d);
      HOST.ack(d, o);
      chk("high addr", 8'h5A, d);
      chk("drive", 8'h00, {7'h0, o});
      chk("chain oe", 8'h01, {7'h0, coe_n});
      HOST.wr_reg(1'b0, 8'h0B);
      HOST.rd_reg(1'b0, d, o);
      chk("in service", 8'h08, d);
      HOST.wr_reg(1'b0, 8'h0A);
      HOST.rd_reg(1'b0, d, o);
      chk("pending", 8'h00, d);
      HOST.wr_reg(1'b0, 8'h20);
      HOST.wr_reg(1'b0, 8'h0B);
      HOST.rd_reg(1'b0, d, o);
      chk("after end", 8'h00, d);
      raise(8'h00);
   endtask : t_three_pulse
   // Pointer form with auto end, two levels, interval 8 ignored
   task automatic t_two_pulse();
      init(8'h13, 8'hA8, 8'h03);
      raise(8'h24);
      HOST.ack(d, o);
      chk("first float", 8'h01, {7'h0, o});
      HOST.ack(d, o);
      chk("vector", 8'hAA, d);
      HOST.wr_reg(1'b0, 8'h0B);
      HOST.rd_reg(1'b0, d, o);
      chk("auto end", 8'h00, d);
      HOST.ack(d, o);
      HOST.ack(d, o);
      chk("vector 5", 8'hAD, d);
      raise(8'h40);
      raise(8'h00);
      HOST.ack(d, o);
      HOST.ack(d, o);
      chk("spurious", 8'hAF, d);
   endtask : t_two_pulse
   task automatic t_mask();
      HOST.wr_reg(1'b1, 8'hFF);
      HOST.rd_reg(1'b1, d, o);
      chk("mask", 8'hFF, d);
      raise(8'h02);
      chk("masked irq", 8'h00, {7'h0, irq});
      chk("float", 8'h01, {7'h0, oe_n});
      HOST.wr_reg(1'b1, 8'hFD);
      HOST.wr_reg(1'b0, 8'h0C);
      HOST.rd_reg(1'b0, d, o);
      chk("poll", 8'h81, d);
   endtask : t_mask
   initial begin
      repeat (6) @(negedge ref_clk_i);
      srst_i = 1'b0;
      t_three_pulse();
      t_two_pulse();
      t_mask();
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
